// ---- design/io_led_pkg.sv ----
// package: constants and carrier types for the terminal status display
`default_nettype none
package io_led_pkg;
  // segment bit positions inside one digit byte {dp,g,f,e,d,c,b,a}
  localparam int SEG_A = 0;
  localparam int SEG_B = 1;
  localparam int SEG_F = 5;
  localparam int SEG_G = 6;
  localparam int SEG_DP = 7;
  // status word bit positions
  localparam int BIT_RELAY = 8;
  localparam int BIT_COMMS_FWD = 7;
  localparam int BIT_COMMS_BWD = 8;
  localparam int BIT_COMMS_CLR = 9;
  // blink period for the dash pattern: time and derived cycle count
  localparam longint CLK_HZ = 10000000;
  localparam longint BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYC = int'(CLK_HZ * BLINK_HALF_MS / 1000);
  localparam int BLINK_W = 23;
  localparam logic [BLINK_W-1:0] BLINK_RST = 23'h000000;
  localparam logic [31:0] SEG_RST = 32'h00000000;

  typedef enum logic [1:0] {SRC_TERMINAL, SRC_COMMS, SRC_OPTION} source_t;

  // terminal side of the drive
  typedef struct packed {
    logic forward_run_input;
    logic backward_run_input;
    logic [4:0] general_input;     // one..five
    logic transistor_output_one;
    logic transistor_output_two;
    logic relay_contact_output;
  } terminals_t;

  typedef struct packed {
    logic [6:0] comms_operation_command; // fwd, bwd, general one..five at bits 0..6
    logic comms_forward_cmd;
    logic comms_backward_cmd;
    logic comms_fault_clear;
  } comms_t;

  typedef struct packed {
    logic [12:0] option_input_bits;
    logic [7:0] option_output_bits;
  } option_t;
endpackage
`default_nettype wire

// ---- design/io_status_led_display.sv ----
// terminal status display for a four-digit seven-segment monitor
`default_nettype none
// What this block does
// - Segment view lights segments a-g of digit 1 for forward, backward and general inputs one..five when closed.
// - Segment view lights segments a and b of digit 3 for transistor outputs one and two when conducting.
// - Segment view lights segment a of digit 4 while the relay normally-open path is closed.
// - With every terminal input off the terminal item's segment view blinks segment g on all four digits.
// - Digit 2 segments f, g and dp carry comms forward, backward and fault clear, only in the comms view.
// - Hex view builds a 16-bit word with unassigned bits zero and shows it as four hex digits.
// - Input word holds forward at bit 0, backward at bit 1, general one..five at bits 2..6, one when closed.
// - Output word holds transistor outputs one and two at bits 0 and 1, one when shorted to common.
// - Output word holds the relay state at bit 8, one when the normally-open path is closed.
// - Comms view shows the received command bits in both formats with the three comms commands at bits 7..9.
// - Comms view uses the command values as received, with no polarity inversion.
// - Option segment view maps inputs 0-7 to digit 1, inputs 8-12 to digit 2 a-e, outputs 0-7 to digit 3.
// - Each up or down key press toggles between segment view and hex view.
module io_status_led_display (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire io_led_pkg::source_t SOURCE,      // which item is shown
  input wire logic SHOW_OUTPUTS,               // hex view: output word instead of input word
  input wire logic KEY_STEP,                   // one-cycle pulse per up/down key press
  input wire io_led_pkg::terminals_t TERMINALS, // asynchronous terminal levels
  input wire io_led_pkg::comms_t COMMS,
  input wire io_led_pkg::option_t OPTION,
  output logic HEX_VIEW,
  output logic [31:0] SEGMENTS                 // digit4..digit1, each {dp,g,f,e,d,c,b,a}, active high
);
  // terminal pins come from outside, so two stages before use
  io_led_pkg::terminals_t term_s1_q, term_s1_d, term_q, term_d;
  io_led_pkg::comms_t comms_q, comms_d;
  io_led_pkg::option_t opt_q, opt_d;
  logic hex_q, hex_d;
  logic [io_led_pkg::BLINK_W-1:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d;
  logic [31:0] seg_q, seg_d;
  logic [15:0] word;
  logic [31:0] seg_view;
  logic [31:0] hex_view;

  // seven-segment glyph for one nibble
  function automatic logic [7:0] glyph(input logic [3:0] n);
    logic [7:0] g;
    g = 8'h00;
    unique case (n)
      4'h0: g = 8'h3F;
      4'h1: g = 8'h06;
      4'h2: g = 8'h5B;
      4'h3: g = 8'h4F;
      4'h4: g = 8'h66;
      4'h5: g = 8'h6D;
      4'h6: g = 8'h7D;
      4'h7: g = 8'h07;
      4'h8: g = 8'h7F;
      4'h9: g = 8'h6F;
      4'hA: g = 8'h77;
      4'hB: g = 8'h7C;
      4'hC: g = 8'h39;
      4'hD: g = 8'h5E;
      4'hE: g = 8'h79;
      4'hF: g = 8'h71;
    endcase
    return g;
  endfunction

  // input capture and view toggle
  always_comb
  begin
    term_s1_d = TERMINALS;
    term_d = term_s1_q;
    comms_d = COMMS;   // same clock domain, values kept as received
    opt_d = OPTION;
    hex_d = KEY_STEP ? ~hex_q : hex_q;
  end

  // blink timer for the all-off dash pattern
  always_comb
  begin
    blink_cnt_d = blink_cnt_q + 1'b1;
    blink_d = blink_q;
    if (blink_cnt_q == io_led_pkg::BLINK_W'(io_led_pkg::BLINK_HALF_CYC - 1))
    begin
      blink_cnt_d = io_led_pkg::BLINK_RST;
      blink_d = ~blink_q;
    end
  end

  // status word for the hex view
  always_comb
  begin
    word = 16'h0000; // unassigned bits stay zero
    unique case (SOURCE)
      io_led_pkg::SRC_TERMINAL:
      begin
        if (SHOW_OUTPUTS)
        begin
          word[0] = term_q.transistor_output_one;
          word[1] = term_q.transistor_output_two;
          word[io_led_pkg::BIT_RELAY] = term_q.relay_contact_output;
        end
        else
        begin
          word[0] = term_q.forward_run_input;
          word[1] = term_q.backward_run_input;
          word[6:2] = term_q.general_input;
        end
      end
      io_led_pkg::SRC_COMMS:
      begin
        if (SHOW_OUTPUTS)
        begin
          word[0] = term_q.transistor_output_one;
          word[1] = term_q.transistor_output_two;
          word[io_led_pkg::BIT_RELAY] = term_q.relay_contact_output;
        end
        else
        begin
          word[6:0] = comms_q.comms_operation_command;
          word[io_led_pkg::BIT_COMMS_FWD] = comms_q.comms_forward_cmd;
          word[io_led_pkg::BIT_COMMS_BWD] = comms_q.comms_backward_cmd;
          word[io_led_pkg::BIT_COMMS_CLR] = comms_q.comms_fault_clear;
        end
      end
      io_led_pkg::SRC_OPTION:
      begin
        if (SHOW_OUTPUTS)
          word[7:0] = opt_q.option_output_bits;
        else
          word[12:0] = opt_q.option_input_bits;
      end
      default: word = 16'h0000; // fourth encoding is illegal
    endcase
  end

  // one glyph per nibble, lowest nibble on the rightmost digit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_digit
      assign hex_view[gi*8 +: 8] = glyph(word[gi*4 +: 4]);
    end
  endgenerate

  // segment view composition
  always_comb
  begin
    seg_view = 32'h00000000;
    unique case (SOURCE)
      io_led_pkg::SRC_TERMINAL,
      io_led_pkg::SRC_COMMS:
      begin
        if (SOURCE == io_led_pkg::SRC_COMMS)
        begin
          seg_view[6:0] = comms_q.comms_operation_command;
          // digit 2 reserved segments used only here
          seg_view[8 + io_led_pkg::SEG_F] = comms_q.comms_forward_cmd;
          seg_view[8 + io_led_pkg::SEG_G] = comms_q.comms_backward_cmd;
          seg_view[8 + io_led_pkg::SEG_DP] = comms_q.comms_fault_clear;
        end
        else
        begin
          seg_view[io_led_pkg::SEG_A] = term_q.forward_run_input;
          seg_view[io_led_pkg::SEG_B] = term_q.backward_run_input;
          seg_view[6:2] = term_q.general_input;
        end
        seg_view[16 + io_led_pkg::SEG_A] = term_q.transistor_output_one;
        seg_view[16 + io_led_pkg::SEG_B] = term_q.transistor_output_two;
        seg_view[24 + io_led_pkg::SEG_A] = term_q.relay_contact_output;
        // dashes only for the plain terminal item; comms shows commands as sent
        if (SOURCE == io_led_pkg::SRC_TERMINAL && seg_view[6:0] == 7'h00)
          seg_view = {4{1'b0, blink_q, 6'h00}};
      end
      io_led_pkg::SRC_OPTION:
      begin
        seg_view[7:0] = opt_q.option_input_bits[7:0];
        seg_view[12:8] = opt_q.option_input_bits[12:8];
        seg_view[23:16] = opt_q.option_output_bits;
      end
      default: seg_view = 32'h00000000;
    endcase
  end

  always_comb
  begin
    seg_d = hex_q ? hex_view : seg_view;
  end

  // all state frozen while the clock enable is low
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      term_s1_q <= '0;
      term_q <= '0;
      comms_q <= '0;
      opt_q <= '0;
      hex_q <= 1'b0;
      blink_cnt_q <= io_led_pkg::BLINK_RST;
      blink_q <= 1'b0;
      seg_q <= io_led_pkg::SEG_RST;
    end
    else if (CLK_EN)
    begin
      term_s1_q <= term_s1_d;
      term_q <= term_d;
      comms_q <= comms_d;
      opt_q <= opt_d;
      hex_q <= hex_d;
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
      seg_q <= seg_d;
    end
  end

  assign HEX_VIEW = hex_q;
  assign SEGMENTS = seg_q;
endmodule // io_status_led_display
`default_nettype wire

// ---- verification/io_front_model.sv ----
// model of the terminal contacts and up/down keys ahead of the display
`default_nettype none
module io_front_model (
  input wire logic clk,
  input wire logic press,
  input wire io_led_pkg::terminals_t contacts,
  output logic key_step,
  output io_led_pkg::terminals_t terminals
);
  timeunit 1ns;
  timeprecision 1ns;
  logic press_q;
  // held key gives one step only, like a real key edge
  always_ff @(posedge clk) press_q <= press;
  assign key_step = press & ~press_q;
  // closed contact reads one
  assign terminals = contacts;
endmodule // io_front_model
`default_nettype wire

// ---- verification/io_led_chk.sv ----
// checker: port-level assertions for the status display
`default_nettype none
module io_led_chk (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire io_led_pkg::source_t SOURCE,
  input wire logic SHOW_OUTPUTS,
  input wire logic KEY_STEP,
  input wire io_led_pkg::terminals_t TERMINALS,
  input wire io_led_pkg::comms_t COMMS,
  input wire io_led_pkg::option_t OPTION,
  input wire logic HEX_VIEW,
  input wire logic [31:0] SEGMENTS
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  // a frozen enable would shift every latency, so those cycles are skipped
  default disable iff (SYS_RST || !CLK_EN);
  // the seven input contacts in status-word order
  wire logic [6:0] ins = {TERMINALS.general_input, TERMINALS.backward_run_input, TERMINALS.forward_run_input};
  sequence s_term;
    (SOURCE == io_led_pkg::SRC_TERMINAL && !HEX_VIEW) [*4];
  endsequence
  sequence s_comms;
    (SOURCE == io_led_pkg::SRC_COMMS && !HEX_VIEW) [*3];
  endsequence
  property p_key;
    KEY_STEP |=> HEX_VIEW != $past(HEX_VIEW);
  endproperty
  a_key: assert property (p_key) else $error("view did not toggle");
  property p_hold;
    !KEY_STEP |=> $stable(HEX_VIEW);
  endproperty
  a_hold: assert property (p_hold) else $error("view changed without key");
  property p_term_seg;
    s_term ##0 $past(ins, 3) != 7'h00 |-> SEGMENTS == {7'h00, $past(TERMINALS.relay_contact_output, 3),
      6'h00, $past(TERMINALS.transistor_output_two, 3), $past(TERMINALS.transistor_output_one, 3), 9'h000, $past(ins, 3)};
  endproperty
  a_term_seg: assert property (p_term_seg) else $error("terminal segments wrong");
  property p_dash;
    s_term ##0 $past(ins, 3) == 7'h00 ##0 $past(ins, 4) == 7'h00 |-> SEGMENTS inside {32'h0, 32'h40404040};
  endproperty
  a_dash: assert property (p_dash) else $error("dash pattern wrong");
  property p_comms;
    s_comms |-> SEGMENTS[15:0] == {$past(COMMS.comms_fault_clear, 2), $past(COMMS.comms_backward_cmd, 2),
      $past(COMMS.comms_forward_cmd, 2), 6'h00, $past(COMMS.comms_operation_command, 2)};
  endproperty
  a_comms: assert property (p_comms) else $error("comms segments wrong");
  property p_hex_dp;
    $past(HEX_VIEW) |-> (SEGMENTS & 32'h80808080) == 32'h0;
  endproperty
  a_hex_dp: assert property (p_hex_dp) else $error("hex digit lit a point");
  property p_hex_top;
    $past(HEX_VIEW) && $past(SOURCE) inside {io_led_pkg::SRC_TERMINAL, io_led_pkg::SRC_COMMS}
      |-> SEGMENTS[31:24] == 8'h3F;
  endproperty
  a_hex_top: assert property (p_hex_top) else $error("unassigned bits not zero");
  property p_opt_seg;
    !$past(HEX_VIEW) && $past(SOURCE) == io_led_pkg::SRC_OPTION |-> SEGMENTS[31:24] == 8'h00 && SEGMENTS[15:13] == 3'h0;
  endproperty
  a_opt_seg: assert property (p_opt_seg) else $error("option segments outside map");
endmodule // io_led_chk
bind io_status_led_display io_led_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .SOURCE(SOURCE),
  .SHOW_OUTPUTS(SHOW_OUTPUTS), .KEY_STEP(KEY_STEP), .TERMINALS(TERMINALS), .COMMS(COMMS), .OPTION(OPTION),
  .HEX_VIEW(HEX_VIEW), .SEGMENTS(SEGMENTS));
`default_nettype wire

// ---- verification/io_status_led_display_tb.sv ----
// self-checking bench for the terminal status display
`default_nettype none
module io_status_led_display_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic show = 1'b0;
  logic press = 1'b0;
  logic en = 1'b1;
  logic key_step;
  logic hex_view;
  logic [31:0] segs;
  io_led_pkg::source_t src = io_led_pkg::SRC_TERMINAL;
  io_led_pkg::terminals_t term = '0;
  io_led_pkg::terminals_t terms;
  io_led_pkg::comms_t comms = '0;
  io_led_pkg::option_t opt = '0;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  io_front_model u_front (.clk(clk), .press(press), .contacts(term), .key_step(key_step), .terminals(terms));
  io_status_led_display dut (.CLK(clk), .SYS_RST(rst), .CLK_EN(en), .SOURCE(src), .SHOW_OUTPUTS(show),
    .KEY_STEP(key_step), .TERMINALS(terms), .COMMS(comms), .OPTION(opt), .HEX_VIEW(hex_view), .SEGMENTS(segs));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, far above the 75 or so cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic key();
    press = 1'b1;
    step(1);
    press = 1'b0;
    step(1);
  endtask
  // own glyph table: 0..F
  function automatic logic [31:0] hex(input logic [15:0] w);
    logic [127:0] t;
    t = 128'h71795E397C776F7F077D6D664F5B063F;
    return {t[w[15:12]*8 +: 8], t[w[11:8]*8 +: 8], t[w[7:4]*8 +: 8], t[w[3:0]*8 +: 8]};
  endfunction
  // outputs lit but no input closed: dashes must replace the whole pattern
  task automatic t_dash();
    term = io_led_pkg::terminals_t'(10'h005);
    step(6);
    chk({31'h0, segs === 32'h0 || segs === 32'h40404040}, 32'h1);
  endtask
  task automatic t_term();
    term = io_led_pkg::terminals_t'(10'h20D);
    step(5);
    chk(segs, 32'h01010005);
    en = 1'b0; // frozen: contacts move, display must not
    term = io_led_pkg::terminals_t'(10'h300);
    step(5);
    chk(segs, 32'h01010005);
    en = 1'b1;
    step(4);
    chk(segs, 32'h00000003);
    term = io_led_pkg::terminals_t'(10'h20D);
    key();
    step(2);
    chk({31'h0, hex_view}, 32'h1);
    chk(segs, hex(16'h0005));
    show = 1'b1;
    step(3);
    chk(segs, hex(16'h0101));
    key();
    step(2);
    chk({31'h0, hex_view}, 32'h0);
  endtask
  task automatic t_comms();
    src = io_led_pkg::SRC_COMMS;
    comms = io_led_pkg::comms_t'(10'h2AD);
    show = 1'b0;
    step(4);
    chk(segs, 32'h0101A055);
    key();
    step(2);
    chk(segs, hex(16'h02D5));
    key();
  endtask
  task automatic t_opt();
    src = io_led_pkg::SRC_OPTION;
    opt = io_led_pkg::option_t'(21'h1ABCA5);
    step(4);
    chk(segs, 32'h00A51ABC);
    key();
    step(2);
    chk(segs, hex(16'h1ABC));
    show = 1'b1;
    step(3);
    chk(segs, hex(16'h00A5));
    // illegal item code: nothing assigned, so the word reads all zero
    src = io_led_pkg::source_t'(2'h3);
    step(2);
    chk(segs, hex(16'h0000));
  endtask
  initial
  begin
    step(20);
    rst = 1'b0;
    step(1);
    t_dash();
    t_term();
    t_comms();
    t_opt();
    finish_test();
  end
endmodule // io_status_led_display_tb
`default_nettype wire
